/* File: inc/udma_consts.svh */
// timing counts, field widths and crc constants of the burst host port
`ifndef UDMA_CONSTS_SVH
`define UDMA_CONSTS_SVH

`define UDMA_WORD_W        16
// ************************************************
// clock periods
// ************************************************
`define UDMA_MCLK_NS       20
`define UDMA_LINK_NS       160
// ************************************************
// strobe spacing: 16.67 M transitions per second, 8.33 MHz fundamental
// ************************************************
`define UDMA_MIN_TRANS_NS  60
`define UDMA_MIN_TRANS_CYC ((`UDMA_MIN_TRANS_NS + `UDMA_LINK_NS - 1) / `UDMA_LINK_NS)
// link cycles between host strobe transitions, per selected mode
`define UDMA_HALF_M0       2'h3
`define UDMA_HALF_M1       2'h2
`define UDMA_HALF_M2       2'h1
`define UDMA_MODE_MAX      2'h2
// ************************************************
// receiver pause before a host termination request
// ************************************************
`define UDMA_RX_PAUSE_NS   200
`define UDMA_RX_PAUSE_CYC  ((`UDMA_RX_PAUSE_NS + `UDMA_MCLK_NS - 1) / `UDMA_MCLK_NS)
// ************************************************
// crc accumulator
// ************************************************
`define UDMA_CRC_SEED      16'hFFFF
`define UDMA_CRC_POLY      16'h1021

`endif

/* File: inc/udma_pkg.sv */
// types shared by the burst host port
package udma_pkg;
  // gray coded along idle, wait, xfer, pause, stop, crc, release
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_WAIT  = 3'h1,
    ST_XFER  = 3'h3,
    ST_PAUSE = 3'h2,
    ST_STOP  = 3'h6,
    ST_CRC   = 3'h7,
    ST_REL   = 3'h5
  } udma_state_t;
endpackage : udma_pkg

/* File: design/udma_crc.sv */
// crc accumulator over one data word per enable
`timescale 1ns/10ps
`include "udma_consts.svh"
module udma_crc #(
  parameter int W = `UDMA_WORD_W
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic         init_i,
  input  wire logic         en_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] crc_o
);
  // one word folded in msb first
  function automatic logic [15:0] udma_fold(input logic [15:0] c, input logic [W-1:0] d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = W - 1; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r  = {r[14:0], 1'b0} ^ (fb ? `UDMA_CRC_POLY : 16'h0000);
    end
    return r;
  endfunction : udma_fold

  logic [15:0] crc_reg;
  logic [15:0] crc_next;

  // seed at burst start, fold on each word
  assign crc_next = init_i ? `UDMA_CRC_SEED : (en_i ? udma_fold(crc_reg, d_i) : crc_reg);
  assign crc_o    = crc_reg;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) crc_reg <= `UDMA_CRC_SEED;
    else          crc_reg <= crc_next;
  end
endmodule : udma_crc

/* File: design/udma_host.sv */
// host end of the ultra dma burst port: burst control, receive path and strobe engine
`timescale 1ns/10ps
`include "udma_consts.svh"
// What this block does
// - burst spans dmack assertion to its negation
// - receiver always ready for two words
// - host asserts dmack only after seeing dmarq
// - host holds stop and ready until strobe; xfer_abort_i or a zero word count negates ready and asserts stop before it
// - receiver pauses and resumes with ready line
// - sender pauses by withholding strobe edges
// - receiver pauses before asking to terminate
// - strobe spacing never below mode minimum
// - data settles before strobe; both edges latch
// - cable transitions capped at 8.33 mhz
// - data owner also drives the strobe
// - burst meanings only while dmack asserted
// - burst replaces multiword dma for data
// - one mode at a time, not above device
// - host sends crc at burst end
// - stop and dmarq handshake ends the burst
// - ignore strobes when dmarq low or stop
module udma_host
  import udma_pkg::*;
#(
  parameter int W = `UDMA_WORD_W
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic         link_clk_i,
  input  wire logic         xfer_start_i,
  input  wire logic         xfer_dir_in_i,
  input  wire logic [15:0]  xfer_words_i,
  input  wire logic [1:0]   xfer_mode_i,
  input  wire logic         xfer_abort_i,
  input  wire logic         rx_pause_i,
  input  wire logic [W-1:0] tx_data_i,
  input  wire logic         tx_valid_i,
  output logic              tx_ready_o,
  output logic      [W-1:0] rx_data_o,
  output logic              rx_valid_o,
  output logic              busy_o,
  output logic              done_o,
  output logic      [15:0]  crc_o,
  input  wire logic         dmarq_i,
  input  wire logic         ddmardy_n_i,
  input  wire logic         dstrobe_i,
  input  wire logic [W-1:0] dd_i,
  output logic              dmack_n_o,
  output logic              stop_o,
  output logic              hdmardy_n_o,
  output logic              hstrobe_o,
  output logic      [W-1:0] dd_o,
  output logic              dd_oe_o
);
  localparam logic [3:0] PAUSE_LAST = 4'(`UDMA_RX_PAUSE_CYC - 1);
  localparam logic [1:0] MIN_GAP    = 2'(`UDMA_MIN_TRANS_CYC);

  // ************************************************
  // controller domain (mclk_i)
  // ************************************************
  udma_state_t st_reg, st_next;
  logic         dmack_n_reg, dmack_n_next, stop_reg, stop_next;
  logic         hdmardy_n_reg, hdmardy_n_next, go_reg, go_next;
  logic         drive_reg, drive_next, done_reg, done_next;
  logic [3:0]   cnt_reg, cnt_next;
  logic [15:0]  words_left_reg;
  logic         dir_in_reg, first_seen_reg;
  logic [1:0]   mode_reg;
  logic [W-1:0] hold_data_reg;
  logic         hold_crc_reg, req_tgl_reg;
  logic [W-1:0] rx_data_reg;
  logic         rx_valid_reg;
  logic [15:0]  crc_val, crc_out_reg;
  logic         crc_init, load_crc;
  logic         dmarq_m1, dmarq_s, dstb_m1, dstb_s, dstb_d;
  logic [W-1:0] dd_m1, dd_s;
  logic         ack_m1, ack_s;
  logic         ack_tgl_reg;

  // pin and handshake inputs pass two flops before use
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      {dmarq_m1, dmarq_s, ack_m1, ack_s} <= 4'h0;
      {dstb_m1, dstb_s, dstb_d}          <= 3'h7;
      dd_m1                              <= '0;
      dd_s                               <= '0;
    end else begin
      {dmarq_m1, dmarq_s} <= {dmarq_i, dmarq_m1};
      {ack_m1, ack_s}     <= {ack_tgl_reg, ack_m1};
      {dstb_m1, dstb_s}   <= {dstrobe_i, dstb_m1};
      dstb_d              <= dstb_s;
      dd_m1               <= dd_i;
      dd_s                <= dd_m1;
    end
  end

  // decode of handshakes and data moves
  wire pending   = req_tgl_reg != ack_s;
  wire in_burst  = (st_reg == ST_XFER) || (st_reg == ST_PAUSE);
  wire rx_edge   = dstb_s ^ dstb_d;                          // both edges latch
  wire rx_take   = rx_edge && in_burst && dir_in_reg && dmarq_s
                   && !stop_reg && !dmack_n_reg;
  wire last_word = (words_left_reg == 16'h0000);
  wire host_end  = last_word || xfer_abort_i;
  wire tx_fire   = tx_valid_i && tx_ready_o;
  wire [1:0] mode_sel = (xfer_mode_i > `UDMA_MODE_MAX) ? `UDMA_MODE_MAX : xfer_mode_i;

  assign tx_ready_o = (st_reg == ST_XFER) && !dir_in_reg && !pending && !last_word
                      && !xfer_abort_i && dmarq_s;
  assign busy_o     = (st_reg != ST_IDLE);
  assign done_o     = done_reg;
  assign crc_o      = crc_out_reg;
  assign rx_data_o  = rx_data_reg;
  assign rx_valid_o = rx_valid_reg;
  assign dmack_n_o  = dmack_n_reg;
  assign stop_o     = stop_reg;
  assign hdmardy_n_o = hdmardy_n_reg;

  // burst sequencing
  always_comb begin
    st_next        = st_reg;
    dmack_n_next   = dmack_n_reg;
    stop_next      = stop_reg;
    hdmardy_n_next = hdmardy_n_reg;
    go_next        = go_reg;
    drive_next     = drive_reg;
    cnt_next       = cnt_reg;
    done_next      = 1'b0;
    crc_init       = 1'b0;
    load_crc       = 1'b0;
    unique case (st_reg)
      ST_IDLE: if (xfer_start_i) st_next = ST_WAIT;       // every data move is a burst
      ST_WAIT: begin
        if (xfer_abort_i) begin
          st_next   = ST_IDLE;
          done_next = 1'b1;
        end else if (dmarq_s) begin
          st_next        = ST_XFER;
          dmack_n_next   = 1'b0;
          stop_next      = 1'b0;
          hdmardy_n_next = !dir_in_reg;
          go_next        = !dir_in_reg;
          drive_next     = !dir_in_reg;
          crc_init       = 1'b1;
        end
      end
      ST_XFER: begin
        if (!dmarq_s) begin
          st_next        = ST_STOP;
          stop_next      = 1'b1;
          go_next        = 1'b0;
          hdmardy_n_next = 1'b1;
        end else if (dir_in_reg) begin
          if (host_end) begin
            st_next        = ST_PAUSE;
            hdmardy_n_next = 1'b1;
            cnt_next       = 4'h0;
          end else if (first_seen_reg) begin
            hdmardy_n_next = rx_pause_i;
          end
        end else if (host_end && !pending) begin
          st_next   = ST_STOP;
          stop_next = 1'b1;
          go_next   = 1'b0;
        end
      end
      ST_PAUSE: begin
        if (!dmarq_s || cnt_reg >= PAUSE_LAST) begin
          st_next   = ST_STOP;
          stop_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      ST_STOP: begin
        if (!dmarq_s && !pending) begin
          st_next    = ST_CRC;
          load_crc   = 1'b1;
          drive_next = 1'b1;
        end
      end
      ST_CRC: begin
        if (!pending) begin
          st_next      = ST_REL;
          dmack_n_next = 1'b1;
        end
      end
      ST_REL: begin
        st_next    = ST_IDLE;
        drive_next = 1'b0;
        stop_next  = 1'b0;
        done_next  = 1'b1;
      end
      default: st_next = ST_IDLE;
    endcase
  end

  // sequencer and pin registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_reg        <= ST_IDLE;
      dmack_n_reg   <= 1'b1;
      stop_reg      <= 1'b0;
      hdmardy_n_reg <= 1'b1;
      {go_reg, drive_reg, done_reg} <= 3'h0;
      cnt_reg       <= 4'h0;
    end else begin
      st_reg        <= st_next;
      dmack_n_reg   <= dmack_n_next;
      stop_reg      <= stop_next;
      hdmardy_n_reg <= hdmardy_n_next;
      {go_reg, drive_reg, done_reg} <= {go_next, drive_next, done_next};
      cnt_reg       <= cnt_next;
    end
  end

  // command setup and word accounting
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      words_left_reg <= 16'h0000;
      {dir_in_reg, first_seen_reg} <= 2'h0;
      mode_reg       <= 2'h0;
    end else begin
      if (xfer_start_i && st_reg == ST_IDLE) begin
        words_left_reg <= xfer_words_i;
        dir_in_reg     <= xfer_dir_in_i;
        mode_reg       <= mode_sel;
      end else if ((tx_fire || rx_take) && !last_word) begin
        words_left_reg <= words_left_reg - 16'h0001;
      end
      if (crc_init)     first_seen_reg <= 1'b0;
      else if (rx_take) first_seen_reg <= 1'b1;
    end
  end

  // word hand-off towards the link engine, and received data
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      hold_data_reg <= '0;
      {hold_crc_reg, req_tgl_reg, rx_valid_reg} <= 3'h0;
      rx_data_reg   <= '0;
      crc_out_reg   <= 16'h0000;
    end else begin
      if (tx_fire || load_crc) begin
        hold_data_reg <= load_crc ? crc_val : tx_data_i;
        hold_crc_reg  <= load_crc;
        req_tgl_reg   <= !req_tgl_reg;
      end
      rx_valid_reg <= rx_take;
      if (rx_take) rx_data_reg <= dd_s;
      if (st_reg == ST_REL) crc_out_reg <= crc_val;
    end
  end

  udma_crc #(.W(W)) u_crc (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .init_i  (crc_init),
    .en_i    (tx_fire || rx_take),
    .d_i     (dir_in_reg ? dd_s : tx_data_i),
    .crc_o   (crc_val)
  );

  // ************************************************
  // link domain (link_clk_i): data and strobe towards the device
  // ************************************************
  logic         lrst_m1, lrst_n;
  logic         go_m1, go_s, drv_m1, drv_s, req_m1, req_s, rdy_m1, rdy_n_s;
  logic [1:0]   mode_m1, mode_s, gap_reg;
  logic         strobe_reg, placed_reg, dd_oe_reg;
  logic [W-1:0] dd_out_reg;

  // reset and controller levels cross on two flops
  always_ff @(posedge link_clk_i) begin
    {lrst_m1, lrst_n}   <= {rst_n_i, lrst_m1};
    {go_m1, go_s}       <= {go_reg, go_m1};
    {drv_m1, drv_s}     <= {drive_reg, drv_m1};
    {req_m1, req_s}     <= {req_tgl_reg, req_m1};
    {rdy_m1, rdy_n_s}   <= {ddmardy_n_i, rdy_m1};
    mode_m1             <= mode_reg;
    mode_s              <= mode_m1;
  end

  // strobe pacing and item handling
  wire [1:0] half_raw = (mode_s == 2'h0) ? `UDMA_HALF_M0 :
                        (mode_s == 2'h1) ? `UDMA_HALF_M1 : `UDMA_HALF_M2;
  wire [1:0] half_cyc = (half_raw < MIN_GAP) ? MIN_GAP : half_raw;
  wire gap_ok   = gap_reg >= half_cyc;
  wire item_new = req_s != ack_tgl_reg;
  wire ld_crc   = item_new && hold_crc_reg && !placed_reg && strobe_reg; // wait for parked strobe
  wire ld_data  = item_new && !hold_crc_reg && go_s && !rdy_n_s && !placed_reg;
  wire fire     = placed_reg && go_s && !rdy_n_s && gap_ok;
  wire drop     = placed_reg && !go_s;
  wire park     = !go_s && !strobe_reg && gap_ok && !placed_reg;     // back to asserted
  wire stb_tgl  = fire || park;

  assign hstrobe_o = strobe_reg;
  assign dd_o      = dd_out_reg;
  assign dd_oe_o   = dd_oe_reg;

  always_ff @(posedge link_clk_i) begin
    if (!lrst_n) begin
      {strobe_reg, placed_reg, ack_tgl_reg, dd_oe_reg} <= 4'h8;
      gap_reg    <= 2'h0;
      dd_out_reg <= '0;
    end else begin
      if (stb_tgl) strobe_reg <= !strobe_reg;
      gap_reg    <= stb_tgl ? 2'h0 : ((gap_reg == 2'h3) ? gap_reg : gap_reg + 2'h1);
      placed_reg <= ld_data ? 1'b1 : ((fire || drop) ? 1'b0 : placed_reg);
      if (ld_crc || fire || drop) ack_tgl_reg <= !ack_tgl_reg;
      if (ld_data || ld_crc) dd_out_reg <= hold_data_reg;
      dd_oe_reg  <= drv_s;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  dmack_after_rq_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(dmack_n_o) |-> $past(dmarq_s)) else $error("dmack asserted without dmarq");
  burst_span_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !dmack_n_o |-> busy_o && st_reg != ST_WAIT) else $error("dmack outside a burst");
  init_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_reg == ST_XFER && $past(st_reg) == ST_XFER && dir_in_reg && !first_seen_reg
     && dmarq_s) |-> $stable(stop_o) && $stable(hdmardy_n_o))
    else $error("stop or ready moved before first strobe");
  dev_term_ack_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_reg == ST_XFER && !dmarq_s) |=> stop_o) else $error("device termination not acked");
  rx_ignore_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rx_valid_o |-> $past(dmarq_s) && !$past(stop_o)) else $error("word taken while ignored");
  pause_first_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ($rose(stop_o) && dir_in_reg && $past(dmarq_s))
      |-> $past(hdmardy_n_o, 1) && $past(hdmardy_n_o, 10))
    else $error("termination without receiver pause");
  crc_release_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(dmack_n_o) |-> ($past(st_reg) == ST_CRC) ##[1:12] done_o)
    else $error("dmack released without crc phase");
  crc_seed_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(dmack_n_o) |-> crc_val == `UDMA_CRC_SEED) else $error("crc not reseeded");
  strobe_gap_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    $changed(hstrobe_o) |-> $past(gap_reg) >= $past(half_cyc)) else $error("strobe too fast");
  data_setup_a: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
    $changed(hstrobe_o) |-> $stable(dd_o)) else $error("data moved with strobe");

  cov_rx_burst_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    dir_in_reg && rx_valid_o ##[1:300] done_o);
  cov_tx_burst_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    !dir_in_reg && tx_fire ##[1:600] done_o);
  cov_dev_term_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    st_reg == ST_XFER && !dmarq_s);
endmodule : udma_host

/* File: test/udma_dev_model.sv */
// behavioural device end of the burst port
`timescale 1ns/10ps
module udma_dev_model (
  input  wire logic        dmack_n_i,
  input  wire logic        stop_i,
  input  wire logic        hdmardy_n_i,
  input  wire logic        hstrobe_i,
  input  wire logic [15:0] dd_i,
  input  wire logic        dd_oe_i,
  output logic             dmarq_o,
  output logic             ddmardy_n_o,
  output logic             dstrobe_o,
  output logic [15:0]      dd_o
);
  logic [15:0] din_q[$];
  logic [15:0] dout_q[$];
  logic [15:0] crc_reg;
  logic        crc_err  = 1'b0; // sticky first mismatch of a command
  logic        dev_term = 1'b0; // device ends a data-in burst itself
  logic        cap_en   = 1'b0;
  realtime     gap_ns   = 80;
  realtime     last_t;
  realtime     min_gap;
  // served modes are nested below fast_mode, and the choice survives host resets
  int          fast_mode = 2;
  logic        slow_err  = 1'b0; // strobe spacing faster than any served mode
  // idle levels of the device lines
  initial begin
    dmarq_o = 1'b0;
    ddmardy_n_o = 1'b1;
    dstrobe_o = 1'b1;
    dd_o = 16'hA5C3;
  end
  // crc over one word, msb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ w[i]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
    end
    return c;
  endfunction : crc_step
  // one burst, always opened by the device request
  task automatic burst(input bit dir_in);
    dmarq_o = 1'b1;
    wait (!dmack_n_i && !stop_i);
    crc_reg = 16'hFFFF;
    min_gap = 1.0e9;
    last_t = -1.0;
    if (dir_in) begin
      while (din_q.size() > 0) begin
        wait (!hdmardy_n_i || stop_i);
        if (stop_i) break;
        dd_o = din_q.pop_front();
        crc_reg = crc_step(crc_reg, dd_o);
        #(gap_ns);
        dstrobe_o = ~dstrobe_o;
        #(gap_ns);
      end
      if (!dev_term) wait (stop_i);
    end else begin
      ddmardy_n_o = 1'b0;
      cap_en = 1'b1;
      wait (stop_i);
    end
    dmarq_o = 1'b0;
    ddmardy_n_o = 1'b1;
    cap_en = 1'b0;
    dstrobe_o = 1'b1;
    dd_o = ~dd_o;
    @(posedge dmack_n_i);
    if (!(dd_oe_i === 1'b1 && dd_i === crc_reg)) crc_err = 1'b1;
  endtask : burst
  // data-out capture on both strobe edges, spacing tracked
  always @(hstrobe_i) begin
    if (cap_en && dmarq_o && !stop_i && !dmack_n_i) begin
      dout_q.push_back(dd_i);
      crc_reg = crc_step(crc_reg, dd_i);
      if (last_t >= 0 && $realtime - last_t < (3 - fast_mode) * 160)
        slow_err = 1'b1;
      if (last_t >= 0 && $realtime - last_t < min_gap) min_gap = $realtime - last_t;
      last_t = $realtime;
    end
  end
endmodule : udma_dev_model

/* File: test/udma_host_tb.sv */
// self-checking bench of the burst host port against the device model
`timescale 1ns/10ps
`include "udma_consts.svh"
`define CHK(a, e) \
  begin \
    num_checks++; \
    if ((a) !== (e)) begin \
      err_total++; \
      $display("Error at %0t: got %h expected %h", $time, (a), (e)); \
    end \
  end
module udma_host_tb;
  logic        mclk_i        = 1'b0;
  logic        link_clk_i    = 1'b0;
  logic        rst_n_i       = 1'b0;
  logic        xfer_start_i  = 1'b0;
  logic        xfer_dir_in_i = 1'b0;
  logic [15:0] xfer_words_i  = 16'h0000;
  logic [1:0]  xfer_mode_i   = 2'h0;
  logic        xfer_abort_i  = 1'b0;
  logic        rx_pause_i    = 1'b0;
  logic [15:0] tx_data_i     = 16'h0000;
  logic        tx_valid_i    = 1'b0;
  logic        tx_ready_o, rx_valid_o, busy_o, done_o;
  logic [15:0] rx_data_o, crc_o, dd_i, dd_o;
  logic        dmarq_i, ddmardy_n_i, dstrobe_i;
  logic        dmack_n_o, stop_o, hdmardy_n_o, hstrobe_o, dd_oe_o;
  int          err_total     = 0;
  int          num_checks    = 0;
  int          cyc           = 0;
  int          seed          = 32'hfcd7;
  logic [15:0] exp_q[$];
  logic [15:0] rx_q[$];
  logic [15:0] w, crc_exp;
  bit          seen;

  udma_host i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
    .xfer_start_i(xfer_start_i), .xfer_dir_in_i(xfer_dir_in_i), .xfer_words_i(xfer_words_i),
    .xfer_mode_i(xfer_mode_i), .xfer_abort_i(xfer_abort_i), .rx_pause_i(rx_pause_i),
    .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .busy_o(busy_o), .done_o(done_o),
    .crc_o(crc_o), .dmarq_i(dmarq_i), .ddmardy_n_i(ddmardy_n_i), .dstrobe_i(dstrobe_i),
    .dd_i(dd_i), .dmack_n_o(dmack_n_o), .stop_o(stop_o), .hdmardy_n_o(hdmardy_n_o),
    .hstrobe_o(hstrobe_o), .dd_o(dd_o), .dd_oe_o(dd_oe_o));
  udma_dev_model i_dev (.dmack_n_i(dmack_n_o), .stop_i(stop_o), .hdmardy_n_i(hdmardy_n_o),
    .hstrobe_i(hstrobe_o), .dd_i(dd_o), .dd_oe_i(dd_oe_o), .dmarq_o(dmarq_i),
    .ddmardy_n_o(ddmardy_n_i), .dstrobe_o(dstrobe_i), .dd_o(dd_i));

  // controller clock and unrelated link clock
  initial forever #10 mclk_i = ~mclk_i;
  initial begin
    #7;
    forever #80 link_clk_i = ~link_clk_i;
  end
  // received word log and hang limit
  always @(posedge mclk_i) begin
    if (rx_valid_o === 1'b1) rx_q.push_back(rx_data_o);
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  function automatic int half_cyc(input logic [1:0] m);
    case (m)
      2'h0: return `UDMA_HALF_M0;
      2'h1: return `UDMA_HALF_M1;
      default: return `UDMA_HALF_M2; // mode 3 clamps to 2
    endcase
  endfunction : half_cyc
  task automatic do_reset();
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (12) @(posedge link_clk_i);
    `CHK(dmack_n_o, 1'b1)
    `CHK(stop_o, 1'b0)
    `CHK(busy_o, 1'b0)
    `CHK(hstrobe_o, 1'b1)
    `CHK(dd_oe_o, 1'b0)
    @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge link_clk_i);
  endtask : do_reset
  task automatic start_burst(input logic dir_in, input logic [15:0] n, input logic [1:0] m);
    repeat (2) @(posedge link_clk_i);
    do @(posedge mclk_i); while (busy_o !== 1'b0);
    xfer_start_i <= 1'b1;
    xfer_dir_in_i <= dir_in;
    xfer_words_i <= n;
    xfer_mode_i <= m;
    @(posedge mclk_i);
    xfer_start_i <= 1'b0;
  endtask : start_burst
  task automatic wait_done();
    seen = 1'b0;
    repeat (4000) begin
      @(posedge mclk_i);
      if (done_o === 1'b1) break;
    end
    seen = (done_o === 1'b1);
  endtask : wait_done
  task automatic end_burst(input string name);
    wait_done();
    `CHK(seen, 1'b1)
    crc_exp = 16'hFFFF;
    foreach (exp_q[i]) crc_exp = i_dev.crc_step(crc_exp, exp_q[i]);
    `CHK(crc_o, crc_exp)
    `CHK(i_dev.crc_err, 1'b0)
    $display("test %s done, mismatches %0d", name, err_total);
  endtask : end_burst
  // ****************************************
  // scenarios
  // ****************************************
  task automatic abort_wait();
    bit acked;
    acked = 1'b0;
    start_burst(1'b0, 16'h0004, 2'h0);
    repeat (40) begin
      @(posedge mclk_i);
      if (dmack_n_o !== 1'b1) acked = 1'b1;
    end
    `CHK(acked, 1'b0)
    xfer_abort_i <= 1'b1;
    wait_done();
    xfer_abort_i <= 1'b0;
    `CHK(seen, 1'b1)
    $display("test abort while waiting done, mismatches %0d", err_total);
  endtask : abort_wait
  task automatic run_in(input int n, input int k, input bit term, input bit pause,
                        input realtime g, input string name);
    int held;
    exp_q = {};
    rx_q = {};
    i_dev.gap_ns = g;
    i_dev.dev_term = term;
    i_dev.crc_err = 1'b0;
    repeat (k) begin
      w = 16'($random(seed));
      exp_q.push_back(w);
      i_dev.din_q.push_back(w);
    end
    fork i_dev.burst(1'b1); join_none
    start_burst(1'b1, 16'(n), 2'h0);
    if (pause) begin
      while (rx_q.size() < 2) @(posedge mclk_i);
      rx_pause_i <= 1'b1;
      repeat (20) @(posedge mclk_i);
      held = rx_q.size();
      `CHK(hdmardy_n_o, 1'b1)
      repeat (20) @(posedge mclk_i);
      `CHK(rx_q.size(), held)
      `CHK(stop_o, 1'b0)
      rx_pause_i <= 1'b0;
    end
    end_burst(name);
    `CHK(rx_q.size(), exp_q.size())
    foreach (exp_q[i]) `CHK(rx_q[i], exp_q[i])
  endtask : run_in
  task automatic run_out(input int n, input logic [1:0] m, input string name);
    exp_q = {};
    i_dev.dout_q = {};
    i_dev.crc_err = 1'b0;
    fork i_dev.burst(1'b0); join_none
    start_burst(1'b0, 16'(n), m);
    repeat (n) begin
      w = 16'($random(seed));
      exp_q.push_back(w);
      tx_data_i <= w;
      tx_valid_i <= 1'b1;
      do @(posedge mclk_i); while (tx_ready_o !== 1'b1);
    end
    tx_valid_i <= 1'b0;
    end_burst(name);
    `CHK(i_dev.dout_q.size(), exp_q.size())
    foreach (exp_q[i]) `CHK(i_dev.dout_q[i], exp_q[i])
    `CHK((i_dev.min_gap >= half_cyc(m) * `UDMA_LINK_NS), 1'b1)
    `CHK(i_dev.slow_err, 1'b0)
  endtask : run_out
  // main sequence
  initial begin
    do_reset();
    abort_wait();
    run_in(6, 6, 1'b0, 1'b0, 80, "data-in prompt");
    run_in(8, 8, 1'b0, 1'b1, 240, "data-in paused");
    run_in(10, 5, 1'b1, 1'b0, 80, "data-in device end");
    for (int m = 0; m < 4; m++) run_out(4 + m, 2'(m), "data-out mode");
    do_reset();
    run_out(3, 2'h2, "data-out after reset");
    tally_and_finish();
  end
endmodule : udma_host_tb
